//--- rtl/sac_pkg.sv
// Purpose: shared constants and types of the conversion control block
// Assumes: 100 MHz hclk, AHB-Lite register access, whole-word transfers
// Notes:   the byte address is decoded from haddr[7:0] only
package sac_pkg;
   localparam int RES_BITS      = 16;
   localparam int SEQ_DEPTH     = 16;
   localparam int SEQ_IW        = 4;
   localparam int FIFO_DEPTH    = 4;
   localparam int FIFO_CW       = 3;
   localparam int CLK_PERIOD_NS = 10;
   // discharge of the mux node, least time
   localparam int DISCH_TIME_NS = 20;
   localparam int DISCH_CYC     =
      (DISCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] DISCH_LOAD = 2'(DISCH_CYC);

   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_STAT     = 8'h04;
   localparam logic [7:0] ADDR_DATA     = 8'h08;
   localparam logic [7:0] ADDR_CFG_BASE = 8'h40;
   localparam logic [7:0] ADDR_CFG_MASK = 8'hC0;
   localparam int         CFG_IDX_LSB   = 2;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   localparam logic [1:0] RNG_FULL_DIFF = 2'h0;
   localparam logic [1:0] RNG_UNIPOLAR  = 2'h1;
   localparam logic [1:0] RNG_BIPOLAR   = 2'h2;
   localparam logic [1:0] RNG_ILLEGAL   = 2'h3;

   localparam logic [RES_BITS-1:0] CODE_MSB  = 16'h8000;
   localparam logic [RES_BITS-1:0] CODE_ZERO = 16'h0000;
   localparam logic [SEQ_IW-1:0]   IDX_TOP   = 4'hF;
   localparam logic [SEQ_IW-1:0]   IDX_ZERO  = 4'h0;

   // one sequencer entry: range kept apart from channel selection
   typedef struct packed {
      logic       gain_comp;
      logic       twos_sel;
      logic [1:0] range;
      logic [2:0] channel;
   } sac_cfg_t;

   typedef struct packed {
      logic              sleep;
      logic [SEQ_IW-1:0] len_m1;
   } sac_ctrl_t;

   typedef struct packed {
      logic [FIFO_CW-1:0] fifo_count;
      logic [SEQ_IW-1:0]  seq_idx;
      logic               pending;
      logic               sleep;
      logic               nap;
      logic               busy;
   } sac_stat_t;

   typedef struct packed {
      logic                valid;
      logic [RES_BITS-1:0] code;
   } sac_data_t;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } sac_aph_t;

   localparam int CFG_W  = $bits(sac_cfg_t);
   localparam int CTRL_W = $bits(sac_ctrl_t);
endpackage : sac_pkg

//--- rtl/sac_conv_ctrl.sv
// Purpose: conversion control of an 8-channel 16-bit SAR converter
// Assumes: all pin inputs are synchronous to hclk; hclk is the conversion
//          oscillator, one approximation step per cycle
// Notes:   results queue in a small FIFO that software drains by reading
//          the data register; a full FIFO stalls the end of conversion
module sac_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   flush,
   input  wire logic                   in_valid,
   output logic                        in_ready,
   input  wire logic [WIDTH-1:0]       in_data,
   output logic                        out_valid,
   input  wire logic                   out_ready,
   output logic [WIDTH-1:0]            out_data,
   output logic [$clog2(DEPTH):0]      count
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   logic [WIDTH-1:0] mem_r   [DEPTH];
   logic [WIDTH-1:0] mem_nxt [DEPTH];
   logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
   logic [CW-1:0]    cnt_r, cnt_nxt;
   logic             push, pop;

   assign in_ready  = (cnt_r != CW'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rd_r];
   assign count     = cnt_r;

   always_comb
   begin
      push    = in_valid && in_ready;
      pop     = out_valid && out_ready;
      mem_nxt = mem_r;
      wr_nxt  = wr_r;
      rd_nxt  = rd_r;
      cnt_nxt = cnt_r;
      if (flush)
      begin
         wr_nxt  = '0;
         rd_nxt  = '0;
         cnt_nxt = '0;
      end
      else
      begin
         if (push)
         begin
            mem_nxt[wr_r] = in_data;
            wr_nxt        = wr_r + AW'(1);
         end
         if (pop)
            rd_nxt = rd_r + AW'(1);
         cnt_nxt = cnt_r + CW'(push) - CW'(pop);
      end
   end

   // storage needs no reset: count guards every read
   always_ff @(posedge clk)
      mem_r <= mem_nxt;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         wr_r  <= wr_nxt;
         rd_r  <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule // sac_fifo

// Overview of operation
// R1: a rising edge on convert_strobe in acquisition, outside sleep and device_reset, starts a conversion on that edge
// R2: the block alternates acquisition (tracking) and conversion phases
// R3: sixteen approximation steps, from half scale down, one bit per step
// R4: the finished 16-bit code goes into the output path
// R5: straight binary is two's complement with the MSB inverted
// R6: full differential range lets configuration pick the code format
// R7: exactly one of three input ranges is ever selected
// R8: input range is held apart from the mux channel selection
// R9: sequencer length is programmable from one to sixteen words
// R10: nap follows each completed conversion, not one aborted by device_reset, and ends on the next conversion start
// R11: a sleep state deeper than nap is selectable by the host
// R12: mux node discharged each conversion and when new config applies
// R13: unipolar range delivers straight binary
// R14: bipolar range delivers two's complement
// R15: busy rises when a conversion starts and falls when it ends
// R16: device_reset high halts conversion and disables the output path
module sac_conv_ctrl (
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic [31:0]                      hrdata,
   output logic                             hreadyout,
   output logic                             hresp,
   input  wire logic                        convert_strobe,
   input  wire logic                        device_reset,
   input  wire logic                        comparator_high,
   output logic                             busy,
   output logic                             acquire,
   output logic [sac_pkg::RES_BITS-1:0]     sampling_capacitor_array,
   output logic                             mux_discharge,
   output logic                             nap,
   output logic                             sleep,
   output logic [2:0]                       mux_channel,
   output logic [1:0]                       core_range,
   output logic                             gain_compression_select,
   output logic                             result_oe
);
   import sac_pkg::*;

   typedef enum logic [1:0] {ST_ACQ, ST_CONV, ST_DONE} sac_state_t;

   sac_state_t          state_r, state_nxt;
   logic [SEQ_IW-1:0]   bit_r, bit_nxt;
   logic [RES_BITS-1:0] code_r, code_nxt;
   logic [1:0]          disch_r, disch_nxt;
   logic                nap_r, nap_nxt, pend_r, pend_nxt;
   logic                prev_r, oe_r, oe_nxt;
   logic [SEQ_IW-1:0]   idx_r, idx_nxt;
   sac_ctrl_t           ctrl_r, ctrl_nxt;
   sac_cfg_t            cfg_r   [SEQ_DEPTH];
   sac_cfg_t            cfg_nxt [SEQ_DEPTH];
   sac_aph_t            aph_r, aph_nxt;
   logic [31:0]         rdata_r, rdata_nxt;
   sac_cfg_t            cur, wcfg;
   sac_stat_t           stat;
   sac_data_t           dread;
   logic                strobe_rise, start, aph_ok, rd_pop, twos;
   logic [RES_BITS-1:0] result;
   logic                f_in_ready, f_out_valid;
   logic [RES_BITS-1:0] f_out_data;
   logic [FIFO_CW-1:0]  f_count;
   logic                push;

   assign cur         = cfg_r[idx_r];
   assign strobe_rise = convert_strobe && !prev_r;
   // sleep ignores strobes; nap does not
   assign start       = strobe_rise && (state_r == ST_ACQ)
                        && !ctrl_r.sleep && !device_reset;        // see R1
   assign aph_ok      = hsel && hready && (htrans == HTRANS_NONSEQ)
                        && (hsize == HSIZE_WORD);
   assign rd_pop      = aph_ok && !hwrite && (haddr[7:0] == ADDR_DATA);
   // format per range; the raw SAR code is straight binary
   assign twos        = (cur.range == RNG_BIPOLAR)                // see R14
                        || ((cur.range == RNG_FULL_DIFF)
                            && cur.twos_sel);                     // see R6
   assign result      = twos ? (code_r ^ CODE_MSB) : code_r;      // see R5 R13
   assign push        = (state_r == ST_DONE) && !device_reset;    // see R4

   assign busy                     = (state_r != ST_ACQ);         // see R15
   assign acquire                  = (state_r == ST_ACQ);         // see R2
   assign sampling_capacitor_array = code_r;
   assign mux_discharge            = (disch_r != 2'h0);
   assign nap                      = nap_r && !ctrl_r.sleep;
   assign sleep                    = ctrl_r.sleep && acquire;     // see R11
   assign mux_channel              = cur.channel;
   assign core_range               = cur.range;                   // see R8
   assign gain_compression_select  = cur.gain_comp;
   assign result_oe                = oe_r;
   assign hrdata                   = rdata_r;
   assign hreadyout                = 1'b1;
   assign hresp                    = 1'b0;

   sac_fifo #(.WIDTH(RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (hclk),
      .rst_n     (hresetn),
      .flush     (device_reset),                                  // see R16
      .in_valid  (push),
      .in_ready  (f_in_ready),
      .in_data   (result),
      .out_valid (f_out_valid),
      .out_ready (rd_pop),
      .out_data  (f_out_data),
      .count     (f_count)
   );

   always_comb
   begin
      stat.fifo_count = f_count;
      stat.seq_idx    = idx_r;
      stat.pending    = pend_r;
      stat.sleep      = sleep;
      stat.nap        = nap;
      stat.busy       = busy;
      dread.valid     = f_out_valid;
      dread.code      = f_out_valid ? f_out_data : CODE_ZERO;
      wcfg            = sac_cfg_t'(hwdata[CFG_W-1:0]);
      aph_nxt.valid   = aph_ok;
      aph_nxt.write   = hwrite;
      aph_nxt.addr    = haddr[7:0];
      rdata_nxt       = 32'h0000_0000;
      ctrl_nxt        = ctrl_r;
      cfg_nxt         = cfg_r;
      pend_nxt        = pend_r;
      if (aph_ok && !hwrite)
      begin
         if (haddr[7:0] == ADDR_CTRL)
            rdata_nxt = 32'(ctrl_r);
         else if (haddr[7:0] == ADDR_STAT)
            rdata_nxt = 32'(stat);
         else if (haddr[7:0] == ADDR_DATA)
            rdata_nxt = 32'(dread);
         else if ((haddr[7:0] & ADDR_CFG_MASK) == ADDR_CFG_BASE)
            rdata_nxt = 32'(cfg_r[haddr[CFG_IDX_LSB +: SEQ_IW]]);
      end
      // a clear at apply time loses to a fresh write
      if (state_r == ST_DONE && push && f_in_ready)
         pend_nxt = 1'b0;
      if (aph_r.valid && aph_r.write)
      begin
         if (aph_r.addr == ADDR_CTRL)
            ctrl_nxt = sac_ctrl_t'(hwdata[CTRL_W-1:0]);           // see R9
         else if ((aph_r.addr & ADDR_CFG_MASK) == ADDR_CFG_BASE)
         begin
            cfg_nxt[aph_r.addr[CFG_IDX_LSB +: SEQ_IW]] = wcfg;
            // the fourth range code is refused, old range kept
            if (wcfg.range == RNG_ILLEGAL)                        // see R7
               cfg_nxt[aph_r.addr[CFG_IDX_LSB +: SEQ_IW]].range =
                  cfg_r[aph_r.addr[CFG_IDX_LSB +: SEQ_IW]].range;
            pend_nxt = 1'b1;
         end
      end
   end

   always_comb
   begin
      state_nxt = state_r;
      bit_nxt   = bit_r;
      code_nxt  = code_r;
      nap_nxt   = nap_r;
      idx_nxt   = idx_r;
      oe_nxt    = !device_reset;
      disch_nxt = (disch_r != 2'h0) ? disch_r - 2'h1 : disch_r;
      if (device_reset)
      begin
         state_nxt = ST_ACQ;                                      // see R16
         code_nxt  = CODE_ZERO;
         disch_nxt = 2'h0;
      end
      else
      begin
         case (state_r)
            ST_ACQ:
               if (start)
               begin
                  state_nxt = ST_CONV;                            // see R1 R2
                  code_nxt  = CODE_MSB;                           // see R3
                  bit_nxt   = IDX_TOP;
                  nap_nxt   = 1'b0;                               // see R10
                  disch_nxt = DISCH_LOAD;                         // see R12
               end
            ST_CONV:
            begin
               // keep the trial bit only if the input is at or above it
               if (!comparator_high)
                  code_nxt[bit_r] = 1'b0;                         // see R3
               if (bit_r == IDX_ZERO)
                  state_nxt = ST_DONE;
               else
               begin
                  code_nxt[bit_r - SEQ_IW'(1)] = 1'b1;
                  bit_nxt = bit_r - SEQ_IW'(1);
               end
            end
            ST_DONE:
               // back-pressure: waits here while the FIFO is full
               if (f_in_ready)
               begin
                  state_nxt = ST_ACQ;
                  nap_nxt   = 1'b1;                               // see R10
                  if (pend_r)
                  begin
                     idx_nxt   = IDX_ZERO;
                     disch_nxt = DISCH_LOAD;                      // see R12
                  end
                  else if (idx_r >= ctrl_r.len_m1)
                     idx_nxt = IDX_ZERO;                          // see R9
                  else
                     idx_nxt = idx_r + SEQ_IW'(1);
               end
            default:
               state_nxt = ST_ACQ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_r <= ST_ACQ;
         bit_r   <= IDX_ZERO;
         code_r  <= CODE_ZERO;
         disch_r <= 2'h0;
         nap_r   <= 1'b0;
         pend_r  <= 1'b0;
         prev_r  <= 1'b0;
         oe_r    <= 1'b0;
         idx_r   <= IDX_ZERO;
         ctrl_r  <= '0;
         cfg_r   <= '{default: '0};
         aph_r   <= '0;
         rdata_r <= 32'h0000_0000;
      end
      else
      begin
         state_r <= state_nxt;
         bit_r   <= bit_nxt;
         code_r  <= code_nxt;
         disch_r <= disch_nxt;
         nap_r   <= nap_nxt;
         pend_r  <= pend_nxt;
         prev_r  <= convert_strobe;
         oe_r    <= oe_nxt;
         idx_r   <= idx_nxt;
         ctrl_r  <= ctrl_nxt;
         cfg_r   <= cfg_nxt;
         aph_r   <= aph_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_start;
      start |=> busy && (code_r == CODE_MSB);
   endproperty
   a_start: assert property (p_start) else $error("no start"); // see R1 R15
   property p_steps;
      $rose(busy) ##1 (!device_reset)[*8] |-> busy;
   endproperty
   a_steps: assert property (p_steps) else $error("short"); // see R3
   property p_end;
      (state_r == ST_CONV) && (bit_r == IDX_ZERO) && !device_reset
         |=> (state_r == ST_DONE);
   endproperty
   a_end: assert property (p_end) else $error("no end"); // see R3
   property p_uni;
      push && (cur.range == RNG_UNIPOLAR) |-> (result == code_r);
   endproperty
   a_uni: assert property (p_uni) else $error("uni fmt"); // see R13
   property p_bip;
      push && (cur.range == RNG_BIPOLAR)
         |-> (result[RES_BITS-1] != code_r[RES_BITS-1]);
   endproperty
   a_bip: assert property (p_bip) else $error("bip fmt"); // see R14 R5
   property p_nap;
      push && f_in_ready |=> nap_r && !busy;
   endproperty
   a_nap: assert property (p_nap) else $error("no nap"); // see R10
   property p_disch;
      start |=> mux_discharge[*2];
   endproperty
   a_disch: assert property (p_disch) else $error("disch"); // see R12
   property p_rst;
      device_reset |=> !busy && !result_oe && (f_count == '0);
   endproperty
   a_rst: assert property (p_rst) else $error("reset"); // see R16
   property p_range;
      core_range != RNG_ILLEGAL;
   endproperty
   a_range: assert property (p_range) else $error("range"); // see R7
   property p_sleep;
      ctrl_r.sleep && acquire |=> !busy;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep"); // see R11

   c_conv:  cover property (push && f_in_ready);
   c_full:  cover property (push && !f_in_ready);
   c_apply: cover property (push && f_in_ready && pend_r);
   c_sleep: cover property (sleep && strobe_rise);
endmodule // sac_conv_ctrl

//--- test/sac_cmp_model.sv
// Purpose: comparator side of the converter, seen by the control block
// Assumes: level is steady for at least one edge before a strobe
// Notes:   input is held as straight binary; the SAR settles on it
module sac_cmp_model (
   input  wire logic                        hclk,
   input  wire logic                        acquire,
   input  wire logic [sac_pkg::RES_BITS-1:0] trial,
   input  wire logic [sac_pkg::RES_BITS-1:0] level,
   output logic                             comparator_high
);
   timeunit 1ns;
   timeprecision 100ps;
   import sac_pkg::*;
   logic [RES_BITS-1:0] held_r;

   // tracks while acquiring, frozen for the whole conversion
   always @(posedge hclk)
      if (acquire)
         held_r <= level;
   assign comparator_high = (held_r >= trial);
endmodule // sac_cmp_model

//--- test/sac_conv_ctrl_bench.sv
// Purpose: self-checking bench of the conversion control block
// Assumes: zero-wait bus slave, comparator model as the analog side
// Notes:   each test task drives the block and judges its answers
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sac_conv_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import sac_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hwrite = 1'b0;
   logic        convert_strobe = 1'b0;
   logic        device_reset = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = HSIZE_WORD;
   logic [15:0] level = 16'h0;
   logic [31:0] hrdata, rd;
   logic        hready, hreadyout, hresp, busy, acquire, comparator_high;
   logic        mux_discharge, nap, sleep, gain_compression_select;
   logic        result_oe;
   logic [15:0] sampling_capacitor_array;
   logic [2:0]  mux_channel;
   logic [1:0]  core_range;
   logic [1:0]  cur_rng = RNG_FULL_DIFF;
   logic        cur_twos = 1'b0;
   int          errors = 0;
   int          checks = 0;
   int          n;

   always #5 hclk = ~hclk;
   assign hready = hreadyout;

   sac_conv_ctrl i_sac_conv_ctrl (.hclk, .hresetn, .hsel(1'b1), .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
      .hresp, .convert_strobe, .device_reset, .comparator_high, .busy,
      .acquire, .sampling_capacitor_array, .mux_discharge, .nap, .sleep,
      .mux_channel, .core_range, .gain_compression_select, .result_oe);

   sac_cmp_model i_sac_cmp_model (.hclk, .acquire,
      .trial(sampling_capacitor_array), .level, .comparator_high);

   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hwrite <= w;
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      `CHK(rd, exp)
      `CHK(hresp, 1'b0)
   endtask

   // expected DATA word: valid flag plus the code in the active format
   function logic [31:0] fmt(input logic [15:0] v);
      logic flip;
      flip = cur_rng == RNG_BIPOLAR || (cur_rng == RNG_FULL_DIFF && cur_twos);
      return {15'h0, 1'b1, v ^ (flip ? CODE_MSB : CODE_ZERO)};
   endfunction

   task set_cfg(input int i, input logic [2:0] ch, input logic [1:0] rg,
                input logic tw, input logic gn);
      sac_cfg_t c;
      c = '{gain_comp: gn, twos_sel: tw, range: rg, channel: ch};
      bus(1'b1, ADDR_CFG_BASE + 8'(4 * i), 32'(c));
      if (rg != RNG_ILLEGAL)
      begin
         cur_rng = rg;
         cur_twos = tw;
      end
   endtask

   // n ends as the count of busy cycles; 41 means still stalled
   task convert(input logic [15:0] lvl, input logic pend, input logic retrig);
      level <= lvl;
      @(posedge hclk);
      convert_strobe <= 1'b1;
      @(posedge hclk);
      #1;
      `CHK(busy, 1'b1)
      `CHK(acquire, 1'b0)
      `CHK(sampling_capacitor_array, CODE_MSB)
      `CHK(mux_discharge, 1'b1)
      `CHK(nap, 1'b0)
      n = 1;
      repeat (40)
      begin
         @(posedge hclk);
         convert_strobe <= retrig && n == 5;
         #1;
         if (busy !== 1'b1)
            break;
         n++;
      end
      if (n == 17)
      begin
         `CHK(nap, 1'b1)
         `CHK(mux_discharge, pend)
      end
      @(posedge hclk);
   endtask

   task t_reset;
      // result_oe is launched by this very edge; look once it has settled
      #1;
      `CHK(result_oe, 1'b1)
      `CHK(acquire, 1'b1)
      @(posedge hclk);
      rdchk(ADDR_STAT, 32'h0);
      rdchk(ADDR_DATA, 32'h0);
      rdchk(8'h20, 32'h0);
      bus(1'b1, ADDR_CTRL, 32'hF);
      rdchk(ADDR_CTRL, 32'hF);
      bus(1'b1, ADDR_CTRL, 32'h0);
      $display("test reset done");
   endtask

   task t_formats;
      static logic [1:0]  rg [4] = '{RNG_FULL_DIFF, RNG_FULL_DIFF,
                                     RNG_UNIPOLAR, RNG_BIPOLAR};
      static logic [15:0] lv [4] = '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF};
      for (int i = 0; i < 4; i++)
      begin
         set_cfg(0, 3'(i + 4), rg[i], i == 1, i == 3);
         convert(lv[i], 1'b1, 1'b0);
         `CHK(n, 17)
         `CHK(core_range, rg[i])
         `CHK(mux_channel, 3'(i + 4))
         `CHK(gain_compression_select, i == 3)
         rdchk(ADDR_DATA, fmt(lv[i]));
      end
      set_cfg(0, 3'h1, RNG_ILLEGAL, 1'b0, 1'b0);
      repeat (2) @(posedge hclk);
      `CHK(core_range, RNG_BIPOLAR)
      $display("test formats done");
   endtask

   task t_retrig;
      convert(16'h1357, 1'b1, 1'b1);
      `CHK(n, 17)
      rdchk(ADDR_STAT, 32'h0000_0102);
      rdchk(ADDR_DATA, fmt(16'h1357));
      $display("test retrigger done");
   endtask

   task t_abort;
      convert(16'h2222, 1'b0, 1'b0);
      convert_strobe <= 1'b1;
      @(posedge hclk);
      convert_strobe <= 1'b0;
      repeat (5) @(posedge hclk);
      device_reset <= 1'b1;
      @(posedge hclk);
      device_reset <= 1'b0;
      #1;
      `CHK(busy, 1'b0)
      `CHK(result_oe, 1'b0)
      repeat (3) @(posedge hclk);
      `CHK(result_oe, 1'b1)
      rdchk(ADDR_DATA, 32'h0);
      $display("test abort done");
   endtask

   task t_fifo;
      for (int i = 0; i < 5; i++)
         convert(16'(i * 4099), 1'b0, 1'b0);
      `CHK(busy, 1'b1)
      for (int i = 0; i < 5; i++)
         rdchk(ADDR_DATA, fmt(16'(i * 4099)));
      rdchk(ADDR_DATA, 32'h0);
      $display("test fifo done");
   endtask

   task t_sleep;
      bus(1'b1, ADDR_CTRL, 32'h10);
      convert_strobe <= 1'b1;
      @(posedge hclk);
      convert_strobe <= 1'b0;
      repeat (3) @(posedge hclk);
      `CHK(busy, 1'b0)
      `CHK(sleep, 1'b1)
      `CHK(nap, 1'b0)
      bus(1'b1, ADDR_CTRL, 32'h0);
      @(posedge hclk);
      `CHK(sleep, 1'b0)
      $display("test sleep done");
   endtask

   task t_seq;
      bus(1'b1, ADDR_CTRL, 32'h2);
      for (int i = 0; i < 3; i++)
         set_cfg(i, 3'(i + 1), RNG_UNIPOLAR, 1'b0, 1'b0);
      convert(16'hABCD, 1'b1, 1'b0);
      rdchk(ADDR_DATA, fmt(16'hABCD));
      for (int k = 0; k < 4; k++)
      begin
         `CHK(mux_channel, 3'(k % 3 + 1))
         `CHK(core_range, RNG_UNIPOLAR)
         convert(16'(k), 1'b0, 1'b0);
         rdchk(ADDR_DATA, fmt(16'(k)));
      end
      $display("test sequencer done");
   endtask

   task tally_and_finish;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_formats;
      t_retrig;
      t_abort;
      t_fifo;
      t_sleep;
      t_seq;
      tally_and_finish;
   end

   // about 440 cycles expected; a hang stops at 20000
   initial
   begin
      #200000;
      errors++;
      tally_and_finish;
   end
endmodule // sac_conv_ctrl_bench
